// ### hw/pskmd_pkg.sv
/*
 * pskmd_pkg: register map, reset values, mode/rate codes, rate limits.
 * assumes a word-indexed register port.
 */
package pskmd_pkg;
    localparam int unsigned FIFO_DEPTH      = 16;
    // register word indices
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_RATE        = 4'h1;
    localparam logic [3:0]  REG_SYMDIV      = 4'h2;
    localparam logic [3:0]  REG_SWEEP_LO    = 4'h3;
    localparam logic [3:0]  REG_SWEEP_HI    = 4'h4;
    localparam logic [3:0]  REG_SWEEP_STEP  = 4'h5;
    localparam logic [3:0]  REG_STATUS      = 4'h6;
    localparam logic [3:0]  REG_FREQ        = 4'h7;
    // ctrl fields
    localparam int unsigned CTRL_MODE_LSB   = 0;
    localparam int unsigned CTRL_RATE_LSB   = 2;
    localparam int unsigned CTRL_ROT_LSB    = 5;
    localparam int unsigned CTRL_TURBO_BIT  = 7;
    localparam int unsigned CTRL_RUN_BIT    = 8;
    // reset values, symdiv minimum, track and soft shifts
    localparam logic [8:0]  CTRL_RST        = 9'h004;
    localparam logic [15:0] RATE_RST        = 16'h0100;
    localparam logic [15:0] SYMDIV_RST      = 16'h0010;
    localparam logic [15:0] SYMDIV_MIN      = 16'h0002;
    localparam logic [23:0] SWEEP_LO_RST    = 24'hF00000;
    localparam logic [23:0] SWEEP_HI_RST    = 24'h100000;
    localparam logic [23:0] SWEEP_STEP_RST  = 24'h000100;
    localparam int unsigned TRACK_SHIFT     = 4;
    localparam int unsigned SOFT_SHIFT      = 5;

    typedef enum logic [1:0] {
        MODE_BPSK, MODE_QPSK, MODE_OQPSK, MODE_8PSK
    } pskmd_mode_t;

    typedef enum logic [2:0] {
        CR_1_1, CR_1_2, CR_3_4, CR_7_8, CR_2_3
    } pskmd_rate_t;

    // data rate in units of 100 bit/s; true when mode and rate may pair and dr lies within their limits
    function automatic logic pskmd_rate_ok(input logic [1:0] m,
                                           input logic [2:0] r,
                                           input logic [15:0] dr);
        logic [15:0] lo;
        logic [15:0] hi;
        case ({m, r})
            {MODE_BPSK, CR_1_2}: begin lo = 16'd24;  hi = 16'd12500; end
            {MODE_BPSK, CR_1_1}: begin lo = 16'd48;  hi = 16'd25000; end
            {MODE_QPSK, CR_1_1},
            {MODE_OQPSK, CR_1_1}: begin lo = 16'd46; hi = 16'd50000; end
            {MODE_QPSK, CR_1_2},
            {MODE_OQPSK, CR_1_2}: begin lo = 16'd48; hi = 16'd25000; end
            {MODE_QPSK, CR_3_4},
            {MODE_OQPSK, CR_3_4}: begin lo = 16'd72; hi = 16'd37500; end
            {MODE_QPSK, CR_7_8},
            {MODE_OQPSK, CR_7_8}: begin lo = 16'd84; hi = 16'd43750; end
            {MODE_8PSK, CR_2_3}: begin lo = 16'd640; hi = 16'd50000; end
            default:             begin lo = 16'hFFFF; hi = 16'h0000; end
        endcase
        return (dr >= lo) && (dr <= hi);
    endfunction : pskmd_rate_ok
endpackage : pskmd_pkg

// ### hw/pskmd_fifo.sv
/*
 * pskmd_fifo: valid/ready fifo with registered output stage.
 * assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pskmd_fifo #(
    parameter int unsigned W = 3,
    parameter int unsigned D = 16
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("pskmd_fifo: D not power of 2");
    end

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0]   cnt, next_cnt;
    logic          next_ov;
    logic          push, pop;

    always_comb begin
        in_ready = (cnt != D[AW:0]);
        push     = in_valid && in_ready;
        // output stage refills whenever memory holds a word and the stage is empty or being taken
        pop      = (cnt != '0) && (!out_valid || out_ready);
        next_wp  = push ? wp + 1'b1 : wp;
        next_rp  = pop ? rp + 1'b1 : rp;
        next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_ov  = pop || (out_valid && !out_ready);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp        <= '0;
            rp        <= '0;
            cnt       <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wp        <= next_wp;
            rp        <= next_rp;
            cnt       <= next_cnt;
            out_valid <= next_ov;
            if (pop) out_data <= mem[rp];
        end
    end

    always_ff @(posedge mclk) begin
        if (push) mem[wp] <= in_data;
    end
endmodule : pskmd_fifo
`default_nettype wire

// ### hw/pskmd_top.sv
/*
 * pskmd_top: psk mapper (tx), soft demapper and rotation (rx),
 * carrier sweep/track control.
 * assumes all neighbours on mclk; registers on a strobe port with
 * read data one cycle later.
 */
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pskmd_top
    import pskmd_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 8,
    parameter int unsigned ERR_W    = 12
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    // encoder symbols in
    input  wire logic                enc_valid,
    output logic                     enc_ready,
    input  wire logic [2:0]          enc_sym,
    // modulator out
    output logic                     tx_strobe,
    output logic [3:0]               tx_phase,
    output logic                     tx_i_neg,
    output logic                     tx_q_neg,
    // filtered samples in
    input  wire logic                rx_valid,
    input  wire logic [SAMPLE_W-1:0] rx_i,
    input  wire logic [SAMPLE_W-1:0] rx_q,
    // decoder outputs
    output logic                     vit_valid,
    output logic                     seq_valid,
    output logic                     turbo_valid,
    output logic [2:0]               soft_i,
    output logic [2:0]               soft_q,
    output logic [2:0]               rx_hard,
    // turbo option and carrier loop
    input  wire logic                turbo_fitted,
    input  wire logic                dec_lock,
    input  wire logic                carrier_lost,
    input  wire logic [ERR_W-1:0]    phase_err,
    output logic [23:0]              nps_freq,
    output logic                     locked
);
    initial begin
        if (SAMPLE_W < SOFT_SHIFT + 1 || ERR_W < 2 || ERR_W > 24)
            $error("pskmd_top: sample or error width unsupported");
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [8:0]  ctrl, next_ctrl;
    logic [15:0] drate, next_drate, symdiv, next_symdiv;
    logic [23:0] sw_lo, next_sw_lo, sw_hi, next_sw_hi;
    logic [23:0] sw_step, next_sw_step;
    logic [31:0] next_rdata;
    logic [1:0]  mode;
    logic [2:0]  crate;
    logic [1:0]  rot;
    logic        cfg_ok, run, fifo_full;

    assign mode  = ctrl[CTRL_MODE_LSB +: 2];
    assign crate = ctrl[CTRL_RATE_LSB +: 3];
    assign rot   = ctrl[CTRL_ROT_LSB +: 2];
    assign run   = ctrl[CTRL_RUN_BIT];
    // bad pairings, out-of-range rates hold mapper idle
    assign cfg_ok = pskmd_rate_ok(mode, crate, drate);

    always_comb begin
        next_ctrl    = ctrl;
        next_drate   = drate;
        next_symdiv  = symdiv;
        next_sw_lo   = sw_lo;
        next_sw_hi   = sw_hi;
        next_sw_step = sw_step;
        next_rdata   = '0;
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:       next_ctrl    = reg_wdata[8:0];
                REG_RATE:       next_drate   = reg_wdata[15:0];
                REG_SYMDIV:     next_symdiv  = (reg_wdata[15:0] < SYMDIV_MIN)
                                             ? SYMDIV_MIN : reg_wdata[15:0];
                REG_SWEEP_LO:   next_sw_lo   = reg_wdata[23:0];
                REG_SWEEP_HI:   next_sw_hi   = reg_wdata[23:0];
                REG_SWEEP_STEP: next_sw_step = reg_wdata[23:0];
                default:        next_ctrl    = ctrl;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:       next_rdata = {23'h0, ctrl};
                REG_RATE:       next_rdata = {16'h0, drate};
                REG_SYMDIV:     next_rdata = {16'h0, symdiv};
                REG_SWEEP_LO:   next_rdata = {8'h0, sw_lo};
                REG_SWEEP_HI:   next_rdata = {8'h0, sw_hi};
                REG_SWEEP_STEP: next_rdata = {8'h0, sw_step};
                REG_STATUS:     next_rdata = {29'h0, fifo_full, locked,
                                              !cfg_ok};
                REG_FREQ:       next_rdata = {8'h0, nps_freq};
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl      <= CTRL_RST;
            drate     <= RATE_RST;
            symdiv    <= SYMDIV_RST;
            sw_lo     <= SWEEP_LO_RST;
            sw_hi     <= SWEEP_HI_RST;
            sw_step   <= SWEEP_STEP_RST;
            reg_rdata <= '0;
        end else begin
            ctrl      <= next_ctrl;
            drate     <= next_drate;
            symdiv    <= next_symdiv;
            sw_lo     <= next_sw_lo;
            sw_hi     <= next_sw_hi;
            sw_step   <= next_sw_step;
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // symbol-rate divider: sym_en at start, half_en mid-symbol
    logic [15:0] dcnt, next_dcnt;
    logic        sym_en, half_en;

    always_comb begin
        sym_en    = (dcnt == 16'h0000);
        half_en   = (dcnt == {1'b0, symdiv[15:1]});
        next_dcnt = (dcnt >= symdiv - 16'h0001) ? 16'h0000 : dcnt + 16'h0001;
    end

    always_ff @(posedge mclk) begin
        if (rst) dcnt <= 16'h0000;
        else     dcnt <= next_dcnt;
    end

    ////////////////////////////////////////////////////////////////////////
    // tx mapper
    logic       fv, fpop;
    logic [2:0] fdata;
    logic       pend, next_pend, pend_bit, next_pend_bit;
    logic       q_hold, next_q_hold;
    logic [3:0] next_phase;
    logic       next_i, next_q, next_strobe, emit, sbit;
    logic [2:0] sym, bidx;

    pskmd_fifo #(.W(3), .D(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (enc_valid),
        .in_ready  (enc_ready),
        .in_data   (enc_sym),
        .out_valid (fv),
        .out_ready (fpop),
        .out_data  (fdata)
    );
    assign fifo_full = !enc_ready;

    always_comb begin
        next_pend     = pend;
        next_pend_bit = pend_bit;
        next_q_hold   = q_hold;
        next_phase    = tx_phase;
        next_i        = tx_i_neg;
        next_q        = tx_q_neg;
        next_strobe   = 1'b0;
        fpop          = 1'b0;
        emit          = 1'b0;
        sym           = fdata;
        sbit          = 1'b0;
        // 8psk: gray word to phase index, phase = 22.5 + 45*idx
        bidx = {fdata[2], fdata[2] ^ fdata[1], fdata[2] ^ fdata[1] ^ fdata[0]};
        if (sym_en && run && cfg_ok) begin
            if (pend) begin
                emit      = 1'b1;
                sbit      = pend_bit;
                next_pend = 1'b0;
            end else if (fv) begin
                fpop = 1'b1;
                emit = 1'b1;
                sbit = fdata[0];
                if (mode == MODE_BPSK && crate == CR_1_2) begin
                    next_pend     = 1'b1;
                    next_pend_bit = fdata[1];
                end
            end
        end
        if (emit) begin
            next_strobe = 1'b1;
            case (mode)
                MODE_BPSK: begin
                    next_phase = sbit ? 4'h8 : 4'h0;
                    next_i     = sbit;
                    next_q     = 1'b0;
                end
                MODE_QPSK, MODE_OQPSK: begin
                    // 00:45 01:135 11:225 10:315, neighbours differ by one bit
                    next_i = sym[0];
                    case (sym[1:0])
                        2'b00:   next_phase = 4'h2;
                        2'b01:   next_phase = 4'h6;
                        2'b11:   next_phase = 4'hA;
                        default: next_phase = 4'hE;
                    endcase
                    if (mode == MODE_QPSK) next_q = sym[1];
                    else                   next_q_hold = sym[1];
                end
                default: begin
                    next_phase = {bidx, 1'b1};
                    next_i     = (bidx >= 3'h2) && (bidx <= 3'h5);
                    next_q     = bidx[2];
                end
            endcase
        end
        // q lags i by half a symbol so they never flip together
        if (mode == MODE_OQPSK && half_en) next_q = q_hold;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pend      <= 1'b0;
            pend_bit  <= 1'b0;
            q_hold    <= 1'b0;
            tx_phase  <= 4'h0;
            tx_i_neg  <= 1'b0;
            tx_q_neg  <= 1'b0;
            tx_strobe <= 1'b0;
        end else begin
            pend      <= next_pend;
            pend_bit  <= next_pend_bit;
            q_hold    <= next_q_hold;
            tx_phase  <= next_phase;
            tx_i_neg  <= next_i;
            tx_q_neg  <= next_q;
            tx_strobe <= next_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rx demapper and rotation
    logic [2:0] si, sq, ri, rq, ni, nq, next_hard;
    logic [2:0] ai, aq, oct;
    logic       to_turbo;

    // turbo takes all when fitted and chosen
    assign to_turbo = turbo_fitted && ctrl[CTRL_TURBO_BIT];

    // saturate a sample to a signed 3-bit soft value
    function automatic logic [2:0] to_soft(input logic [SAMPLE_W-1:0] s);
        logic signed [SAMPLE_W-1:0] v;
        v = $signed(s) >>> SOFT_SHIFT;
        if (v > 3)       return 3'h3;
        else if (v < -4) return 3'h4;
        else             return v[2:0];
    endfunction : to_soft

    function automatic logic [2:0] neg3(input logic [2:0] x);
        return (x == 3'h4) ? 3'h3 : 3'(-x);
    endfunction : neg3

    function automatic logic [2:0] abs3(input logic [2:0] x);
        return x[2] ? neg3(x) : x;
    endfunction : abs3

    always_comb begin
        si = to_soft(rx_i);
        sq = to_soft(rx_q);
        case (rot)
            2'h1:    begin ri = sq;       rq = si;       end
            2'h2:    begin ri = neg3(sq); rq = si;       end
            2'h3:    begin ri = si;       rq = neg3(sq); end
            default: begin ri = si;       rq = sq;       end
        endcase
        ni = rx_valid ? ri : soft_i;
        nq = rx_valid ? rq : soft_q;
        ai = abs3(ri);
        aq = abs3(rq);
        // octant of the rotated vector, 0 = 0..45 degrees
        case ({rq[2], ri[2]})
            2'b00:   oct = (aq > ai) ? 3'h1 : 3'h0;
            2'b01:   oct = (aq > ai) ? 3'h2 : 3'h3;
            2'b11:   oct = (aq > ai) ? 3'h5 : 3'h4;
            default: oct = (aq > ai) ? 3'h6 : 3'h7;
        endcase
        case (mode)
            MODE_BPSK: next_hard = {2'b00, ri[2]};
            MODE_8PSK: next_hard = oct ^ (oct >> 1);
            default:   next_hard = {1'b0, rq[2], ri[2]};
        endcase
        if (!rx_valid) next_hard = rx_hard;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_i      <= 3'h0;
            soft_q      <= 3'h0;
            rx_hard     <= 3'h0;
            vit_valid   <= 1'b0;
            seq_valid   <= 1'b0;
            turbo_valid <= 1'b0;
        end else begin
            soft_i      <= ni;
            soft_q      <= nq;
            rx_hard     <= next_hard;
            turbo_valid <= rx_valid && to_turbo;
            vit_valid   <= rx_valid && !to_turbo;
            seq_valid   <= rx_valid && !to_turbo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carrier sweep / track
    typedef enum logic {ST_SWEEP, ST_TRACK} pskmd_state_t;
    pskmd_state_t st, next_st;
    logic [23:0]  next_freq, trim;

    always_comb begin
        next_st   = st;
        next_freq = nps_freq;
        trim      = 24'($signed(phase_err) >>> TRACK_SHIFT);
        case (st)
            ST_SWEEP: begin
                if (dec_lock && !carrier_lost) begin
                    next_st = ST_TRACK;
                end else if (sym_en) begin
                    // wrap back to the low edge once at or past the high edge
                    if (nps_freq - sw_lo >= sw_hi - sw_lo) next_freq = sw_lo;
                    else next_freq = nps_freq + sw_step;
                end
            end
            ST_TRACK: begin
                if (carrier_lost || !dec_lock) next_st = ST_SWEEP;
                else if (sym_en) next_freq = nps_freq + trim;
            end
            default: next_st = ST_SWEEP;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st       <= ST_SWEEP;
            nps_freq <= SWEEP_LO_RST;
        end else begin
            st       <= next_st;
            nps_freq <= next_freq;
        end
    end
    assign locked = (st == ST_TRACK);
endmodule : pskmd_top
`default_nettype wire

// ### verif/pskmd_props.sv
/*
 * pskmd_props: port assertions for pskmd_top.
 * assumes one clock, sync active-high rst.
 */
`timescale 1ns/1ps
`default_nettype none
module pskmd_props #(
    parameter int unsigned ERR_W = 12
) (
    // clock and reset
    input wire logic             mclk,
    input wire logic             rst,
    // rx path
    input wire logic             rx_valid,
    input wire logic             turbo_fitted,
    input wire logic             vit_valid,
    input wire logic             seq_valid,
    input wire logic             turbo_valid,
    // tx path
    input wire logic             tx_strobe,
    input wire logic [3:0]       tx_phase,
    input wire logic             tx_i_neg,
    // carrier loop
    input wire logic             dec_lock,
    input wire logic             carrier_lost,
    input wire logic [ERR_W-1:0] phase_err,
    input wire logic [23:0]      nps_freq,
    input wire logic             locked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_route_one: assert property (
        rx_valid |=> vit_valid ^ turbo_valid)
        else $error("not one decoder");
    a_route_quiet: assert property (
        !rx_valid |=> !(vit_valid || seq_valid || turbo_valid))
        else $error("strobe, no sample");
    a_turbo_fit: assert property (
        turbo_valid |-> $past(turbo_fitted))
        else $error("turbo not fitted");
    a_seq_vit: assert property (seq_valid |-> vit_valid)
        else $error("seq without vit");
    a_sym_pulse: assert property (tx_strobe |=> !tx_strobe)
        else $error("long strobe");
    a_i_sign: assert property (
        tx_strobe && tx_phase != 4'h4 && tx_phase != 4'hC |->
        tx_i_neg == (tx_phase > 4'h4 && tx_phase < 4'hC))
        else $error("i sign wrong");
    a_lock_enter: assert property (
        !locked && dec_lock && !carrier_lost |=> locked)
        else $error("lock not taken");
    a_lock_leave: assert property (
        locked && (carrier_lost || !dec_lock) |=> !locked)
        else $error("lock kept");
    a_track_hold: assert property (
        locked && phase_err < 12'h010 |=> $stable(nps_freq))
        else $error("freq moved");
endmodule : pskmd_props
bind pskmd_top pskmd_props #(.ERR_W(ERR_W)) props_u (.*);
`default_nettype wire

// ### verif/pskmd_enc_model.sv
/*
 * pskmd_enc_model: encoder side, offers one word per go pulse.
 * assumes go only while no word is pending.
 */
`timescale 1ns/1ps
`default_nettype none
module pskmd_enc_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // bench control
    input  wire logic       go,
    input  wire logic [2:0] word,
    // encoder stream
    input  wire logic       enc_ready,
    output logic            enc_valid,
    output logic [2:0]      enc_sym
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            enc_valid <= 1'b0;
            enc_sym   <= 3'h0;
        end else if (go) begin
            enc_valid <= 1'b1;
            enc_sym   <= word;
        end else if (!enc_valid || enc_ready) begin
            enc_valid <= 1'b0;
            enc_sym   <= ~enc_sym; // idle bus toggles between the last word and its inverse
        end
    end
endmodule : pskmd_enc_model
`default_nettype wire

// ### verif/pskmd_top_tb_top.sv
/*
 * pskmd_top_tb_top: self-checking bench for pskmd_top.
 * assumes the encoder model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module pskmd_top_tb_top;
    import pskmd_pkg::*;
    typedef struct packed {
        logic [3:0]  tx;
        logic [11:0] ctrl;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [3:0]  e1;
        logic [3:0]  e2;
    } pskmd_row_t;
    logic        mclk;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  word = 3'h0;
    logic        rx_valid = 1'b0;
    logic [7:0]  rx_i = 8'h00;
    logic [7:0]  rx_q = 8'h00;
    logic        turbo_fitted = 1'b0;
    logic        dec_lock = 1'b0;
    logic        carrier_lost = 1'b0;
    logic [11:0] phase_err = 12'h000;
    logic [31:0] reg_rdata, v;
    logic        enc_valid, enc_ready, tx_strobe, tx_i_neg, tx_q_neg;
    logic [2:0]  enc_sym, soft_i, soft_q, rx_hard;
    logic [3:0]  tx_phase;
    logic        vit_valid, seq_valid, turbo_valid, locked;
    logic [23:0] nps_freq, f0;
    int          err_total = 0;
    int          checked = 0;
    int          n, k;
    logic [31:0] rv [6] = '{CTRL_RST, RATE_RST, SYMDIV_RST, SWEEP_LO_RST,
                            SWEEP_HI_RST, SWEEP_STEP_RST};
    // {reject, ctrl, rate}; last row stays refused
    logic [31:0] rj [10] = '{32'h1_100_002F, 32'h0_100_61A8, 32'h1_100_61A9,
        32'h0_10E_AAE6, 32'h1_10E_AAE7, 32'h1_109_927D, 32'h1_113_027F,
        32'h0_113_0280, 32'h1_10F_03E8, 32'h1_108_03E8};
    pskmd_row_t  rows [22] = '{40'h0_000_20_E0_1_7, 40'h0_020_20_E0_7_1,
        40'h0_040_20_E0_1_1, 40'h0_060_20_E0_1_1, 40'h0_000_7F_80_3_4,
        40'h0_020_7F_80_4_3, 40'h0_040_7F_80_3_3, 40'h0_060_7F_80_3_3,
        40'h1_100_00_00_0_0, 40'h1_100_01_00_8_0, 40'h1_101_00_00_2_0,
        40'h1_101_01_00_6_0, 40'h1_101_03_00_A_0, 40'h1_101_02_00_E_0,
        40'h1_113_00_00_1_0, 40'h1_113_01_00_3_0, 40'h1_113_03_00_5_0,
        40'h1_113_02_00_7_0, 40'h1_113_06_00_9_0, 40'h1_113_07_00_B_0,
        40'h1_113_05_00_D_0, 40'h1_113_04_00_F_0};
    pskmd_top dut_u (.*);
    pskmd_enc_model enc_u (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // returns with the word pending if the fifo refuses it
    task automatic push(input logic [2:0] w);
        @(posedge mclk);
        word <= w;
        go   <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        #1;
        for (k = 0; k < 8 && enc_valid === 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
    endtask : push
    task automatic wait_sym();
        for (k = 0; k < 100; k++) begin
            @(posedge mclk);
            #1;
            if (tx_strobe === 1'b1) break;
        end
    endtask : wait_sym
    task automatic samp(input logic [7:0] i, input logic [7:0] q);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_i     <= i;
        rx_q     <= q;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_i     <= ~i;
        rx_q     <= ~q;
        #1;
    endtask : samp
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #500000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1 chk(nps_freq, 24'hF00000);
        chk(enc_ready, 1'b1);
        for (n = 0; n < 6; n++) begin
            rd(n[3:0], v);
            chk(v, rv[n]);
        end
        rd(4'h9, v);
        chk(v, 32'h0);
        $display("reset values done");
        wr(REG_SYMDIV, 32'h4);
        wr(REG_RATE, 32'h400);
        for (n = 0; n < 22; n++) begin
            wr(REG_CTRL, {20'h0, rows[n].ctrl});
            if (rows[n].tx == 4'h1) begin
                push(rows[n].a[2:0]);
                wait_sym();
                chk(tx_phase, rows[n].e1);
            end else begin
                samp(rows[n].a, rows[n].b);
                chk(soft_i, rows[n].e1);
                chk(soft_q, rows[n].e2);
                chk(rx_hard, {2'b00, rows[n].e1[2]});
            end
        end
        $display("mapping table done");
        wr(REG_CTRL, 32'h080);
        for (n = 0; n < 2; n++) begin
            turbo_fitted <= n[0];
            samp(8'h20, 8'h20);
            chk(turbo_valid, n[0]);
            chk(vit_valid, !n[0]);
        end
        wr(REG_CTRL, 32'h104);
        push(3'b010);
        wait_sym();
        chk(tx_phase, 4'h0);
        wait_sym();
        chk(tx_phase, 4'h8);
        wr(REG_CTRL, 32'h102);
        push(3'b000);
        wait_sym();
        push(3'b010);
        wait_sym();
        chk({tx_i_neg, tx_q_neg, tx_phase}, 6'h0E);
        repeat (3) @(posedge mclk);
        #1 chk(tx_q_neg, 1'b1);
        $display("routing and offset done");
        for (n = 0; n < 10; n++) begin
            wr(REG_RATE, {16'h0, rj[n][15:0]});
            wr(REG_CTRL, {20'h0, rj[n][27:16]});
            rd(REG_STATUS, v);
            chk(v[0], rj[n][28]);
        end
        // refused config: fill until the encoder stalls
        n = 0;
        while (n < 24 && enc_valid !== 1'b1) begin
            push(n[2:0]);
            n++;
        end
        chk(enc_ready, 1'b0);
        rd(REG_STATUS, v);
        chk(v[2], 1'b1);
        wr(REG_CTRL, 32'h100);
        k = 0;
        repeat (300) begin
            @(posedge mclk);
            #1;
            if (tx_strobe === 1'b1) k++;
        end
        chk(k, n);
        chk(enc_ready, 1'b1);
        $display("rate limits and fifo done");
        f0 = nps_freq;
        for (k = 0; k < 20 && nps_freq === f0; k++) @(posedge mclk) #1;
        chk(24'(nps_freq - f0), 24'h000100);
        @(posedge mclk);
        dec_lock <= 1'b1;
        @(posedge mclk);
        #1 chk(locked, 1'b1);
        f0 = nps_freq;
        repeat (8) @(posedge mclk);
        #1 chk(nps_freq, f0);
        @(posedge mclk);
        phase_err <= 12'h100;
        #1 f0 = nps_freq;
        for (k = 0; k < 20 && nps_freq === f0; k++) @(posedge mclk) #1;
        chk(24'(nps_freq - f0), 24'h000010);
        @(posedge mclk);
        carrier_lost <= 1'b1;
        @(posedge mclk);
        #1 chk(locked, 1'b0);
        $display("carrier lock done");
        stop_test();
    end
endmodule : pskmd_top_tb_top
`default_nettype wire
